// ==== core/eicp_cfg_mem.sv ====
// word store behind the configuration port
// assumes the caller merges byte enables before writing a whole word
`timescale 1ns/1ps
module eicp_cfg_mem (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // access
    input wire logic [eicp_pkg::MEM_AW-1:0] addr_i,
    input wire logic wr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] rdata_o
);

    eicp_pkg::eicp_mem_state_type st;
    eicp_pkg::eicp_mem_state_type next_st;

    // read data always registered, one cycle after the address
    always_comb begin
        next_st = st;
        next_st.rdata = st.words[addr_i];
        if (wr_i) begin
            next_st.words[addr_i] = wdata_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;

endmodule // eicp_cfg_mem

// ==== core/eicp_core.sv ====
// interrupt request logic and configuration port of the endpoint
// assumes user logic on the same clock, inputs synchronous to it,
// and a transaction layer that takes one message per msg_ready_i
`timescale 1ns/1ps

// Functional notes
// - accepted pulse acknowledges; user drops strobe the next cycle.
// - assert message goes out only when interrupt disable bit is zero.
// - withdrawal is acknowledged, strobe dropped, then deassert message sent.
// - nonzero msi vector is acknowledged and produces one msi write.
// - msi address from address fields, payload from data field.
// - short address form unless upper address field is nonzero.
// - user overrides low data bits, count is lesser of capable, enabled.
// - vector bits beyond the vector count are dropped; those payload bits keep the data field.
// - user checks mask register itself; device never looks at it.
// - address 9:0 word, 17:10 function; read data valid with done.
// - write uses address, data, byte enables, strobe; done when finished.
// - root port override lets type-1 header writes change read-only bits.
// - msi writes while msi enabled, legacy messages otherwise.
// - command bit 10 set blocks legacy assert messages; deassert still sent.
module eicp_core (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // port mode
    input wire logic root_port_mode_i,
    // legacy interrupt handshake
    input wire logic int_req_i,
    input wire logic int_pending_i,
    output logic int_sent_o,
    // msi handshake and mode status
    input wire logic [31:0] msi_int_i,
    output logic msi_sent_o,
    output logic msi_enable_o,
    output logic [2:0] msi_mmenable_o,
    output logic msix_enable_o,
    output logic [15:0] command_o,
    // configuration port
    input wire logic [17:0] cfg_addr_i,
    input wire logic [31:0] cfg_write_data_i,
    input wire logic [3:0] cfg_byte_enable_i,
    input wire logic cfg_write_i,
    input wire logic cfg_read_i,
    input wire logic type1_readonly_override_i,
    output logic [31:0] cfg_read_data_o,
    output logic cfg_done_o,
    // message path to the transaction layer
    output eicp_pkg::eicp_msg_type msg_o,
    input wire logic msg_ready_i
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------

    // bits software may change in a word
    function automatic logic [31:0] eicp_wmask(input logic [9:0] w,
                                               input logic ovr);
        if (ovr && w <= eicp_pkg::TYPE1_LAST_WORD) begin
            eicp_wmask = 32'hffff_ffff;
        end else if (w == eicp_pkg::ID_WORD) begin
            eicp_wmask = 32'h0000_0000;
        end else if (w == eicp_pkg::CMD_WORD) begin
            eicp_wmask = eicp_pkg::CMD_WMASK;
        end else if (w == eicp_pkg::MSI_CTRL_WORD) begin
            eicp_wmask = eicp_pkg::MSI_CTRL_WMASK;
        end else if (w == eicp_pkg::MSIX_CTRL_WORD) begin
            eicp_wmask = eicp_pkg::MSIX_CTRL_WMASK;
        end else begin
            eicp_wmask = 32'hffff_ffff;
        end
    endfunction

    // function 0 and a word inside the store
    function automatic logic eicp_hit(input logic [17:0] a);
        eicp_hit = (a[17:10] == 8'h00) &&
                   (a[9:eicp_pkg::MEM_AW] == '0);
    endfunction

    // ------------------------------------------------------------
    // state and sub-blocks
    // ------------------------------------------------------------

    eicp_pkg::eicp_state_type st;
    eicp_pkg::eicp_state_type next_st;
    eicp_pkg::eicp_msg_type msi_msg;
    logic [31:0] vmask;
    logic [31:0] mem_rdata;
    logic [31:0] mem_wdata;
    logic [31:0] bmask;
    logic mem_wr;
    logic [9:0] word;
    logic override;

    // addresses arrive as dword indices, no shift here
    assign word = cfg_addr_i[9:0];
    assign override = root_port_mode_i && type1_readonly_override_i;

    eicp_cfg_mem u_mem (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .addr_i(cfg_addr_i[eicp_pkg::MEM_AW-1:0]),
        .wr_i(mem_wr),
        .wdata_i(mem_wdata),
        .rdata_o(mem_rdata)
    );

    eicp_msi_fmt u_fmt (
        .mme_i(st.mme),
        .addr_lo_i(st.addr_lo),
        .addr_hi_i(st.addr_hi),
        .data_i(st.msg_data),
        .vector_i(msi_int_i),
        .msg_o(msi_msg),
        .vmask_o(vmask)
    );

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------

    // merged write word; the old word comes from the registered read
    always_comb begin
        bmask = {{8{cfg_byte_enable_i[3]}}, {8{cfg_byte_enable_i[2]}},
                 {8{cfg_byte_enable_i[1]}}, {8{cfg_byte_enable_i[0]}}};
        bmask = bmask & eicp_wmask(word, override);
        mem_wdata = (mem_rdata & ~bmask) | (cfg_write_data_i & bmask);
    end

    always_comb begin
        next_st = st;
        mem_wr = 1'b0;
        // interrupt engine: one request at a time, legacy or msi
        case (st.irq)
            eicp_pkg::ST_IDLE: begin
                if (st.msi_en && msi_int_i != 32'h0000_0000) begin
                    next_st.irq = eicp_pkg::ST_ACK;
                    next_st.is_msi = 1'b1;
                    next_st.send = 1'b1;
                    next_st.msg = msi_msg;
                end else if (!st.msi_en && int_req_i) begin
                    next_st.irq = eicp_pkg::ST_ACK;
                    next_st.is_msi = 1'b0;
                    next_st.msg = '0;
                    if (int_pending_i) begin
                        next_st.msg.kind = eicp_pkg::MSG_ASSERT_INTA;
                        next_st.send = !st.command[eicp_pkg::INTX_DIS_BIT];
                    end else begin
                        next_st.msg.kind = eicp_pkg::MSG_DEASSERT_INTA;
                        next_st.send = 1'b1;
                    end
                end
            end
            eicp_pkg::ST_ACK: begin
                // strobe is dropped by now, so no second capture
                next_st.msg.valid = st.send;
                if (st.send) begin
                    next_st.irq = eicp_pkg::ST_MSG;
                end else begin
                    next_st.irq = eicp_pkg::ST_IDLE;
                end
            end
            eicp_pkg::ST_MSG: begin
                if (msg_ready_i) begin
                    next_st.msg.valid = 1'b0;
                    next_st.irq = eicp_pkg::ST_IDLE;
                end
            end
            default: begin
                next_st.irq = eicp_pkg::ST_IDLE;
            end
        endcase
        // config port: take, access with read-modify-write, done
        case (st.cfg)
            eicp_pkg::CS_IDLE: begin
                if (cfg_read_i || cfg_write_i) begin
                    next_st.cfg = eicp_pkg::CS_ACC;
                end
            end
            eicp_pkg::CS_ACC: begin
                next_st.cfg = eicp_pkg::CS_DONE;
                next_st.rdata = 32'h0000_0000;
                if (eicp_hit(cfg_addr_i)) begin
                    next_st.rdata = mem_rdata;
                    if (word == eicp_pkg::MSI_CTRL_WORD) begin
                        next_st.rdata[eicp_pkg::MMC_LSB +: 3] =
                            eicp_pkg::MMC_CFG;
                    end
                end
                if (cfg_write_i && eicp_hit(cfg_addr_i)) begin
                    mem_wr = 1'b1;
                    // mask word is stored only, never used here
                    case (word)
                        eicp_pkg::CMD_WORD: begin
                            next_st.command = mem_wdata[15:0];
                        end
                        eicp_pkg::MSI_CTRL_WORD: begin
                            next_st.msi_en = mem_wdata[eicp_pkg::MSI_EN_BIT];
                            next_st.mme = mem_wdata[eicp_pkg::MME_LSB +: 3];
                        end
                        eicp_pkg::MSI_ADDR_LO_WORD: begin
                            next_st.addr_lo = {mem_wdata[31:2], 2'b00};
                        end
                        eicp_pkg::MSI_ADDR_HI_WORD: begin
                            next_st.addr_hi = mem_wdata;
                        end
                        eicp_pkg::MSI_DATA_WORD: begin
                            next_st.msg_data = {16'h0000, mem_wdata[15:0]};
                        end
                        eicp_pkg::MSIX_CTRL_WORD: begin
                            next_st.msix_en =
                                mem_wdata[eicp_pkg::MSIX_EN_BIT];
                        end
                        default: begin
                        end
                    endcase
                end
            end
            eicp_pkg::CS_DONE: begin
                next_st.cfg = eicp_pkg::CS_IDLE;
            end
            default: begin
                next_st.cfg = eicp_pkg::CS_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers and outputs
    // ------------------------------------------------------------

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // acknowledges are decoded from state, one cycle each
    assign int_sent_o = (st.irq == eicp_pkg::ST_ACK) && !st.is_msi;
    assign msi_sent_o = (st.irq == eicp_pkg::ST_ACK) && st.is_msi;
    assign msi_enable_o = st.msi_en;
    assign msi_mmenable_o = st.mme;
    assign msix_enable_o = st.msix_en;
    assign command_o = st.command;
    assign cfg_read_data_o = st.rdata;
    assign cfg_done_o = (st.cfg == eicp_pkg::CS_DONE);
    assign msg_o = st.msg;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------

    sent_pulse_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        int_sent_o |=> !int_sent_o)
        else $error("legacy accepted longer than one cycle");

    assert_block_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        int_sent_o && st.msg.kind == eicp_pkg::MSG_ASSERT_INTA &&
        st.command[eicp_pkg::INTX_DIS_BIT] |=> !msg_o.valid[*2])
        else $error("assert message sent while disabled");

    deassert_msg_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        int_sent_o && st.msg.kind == eicp_pkg::MSG_DEASSERT_INTA |=>
        msg_o.valid && msg_o.kind == eicp_pkg::MSG_DEASSERT_INTA)
        else $error("withdrawal without deassert message");

    msi_write_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        msi_sent_o |=> msg_o.valid &&
        msg_o.kind inside {eicp_pkg::MSG_MSI32, eicp_pkg::MSG_MSI64})
        else $error("msi accepted without a memory write");

    addr_form_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        st.irq == eicp_pkg::ST_IDLE && st.msi_en && msi_int_i != '0 |=>
        (msg_o.kind == eicp_pkg::MSG_MSI64) == ($past(st.addr_hi) != '0))
        else $error("msi address form does not follow upper address");

    vec_mask_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        st.irq == eicp_pkg::ST_IDLE && st.msi_en && msi_int_i != '0 |=>
        ((msg_o.data ^ $past(st.msg_data)) & ~$past(vmask)) == '0)
        else $error("vector bits leak beyond enabled vectors");

    mode_sel_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        st.irq == eicp_pkg::ST_IDLE && st.msi_en && msi_int_i == '0
        |=> !int_sent_o)
        else $error("legacy request taken in msi mode");

    cfg_done_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        st.cfg == eicp_pkg::CS_IDLE && (cfg_read_i || cfg_write_i)
        |-> !cfg_done_o ##1 !cfg_done_o ##1 cfg_done_o ##1 !cfg_done_o)
        else $error("config done not two cycles after request");

    func_zero_a: assert property (
        @(posedge clock_i) disable iff (!rst_n_i)
        st.cfg == eicp_pkg::CS_ACC && cfg_addr_i[17:10] != 8'h00
        |=> cfg_read_data_o == 32'h0000_0000)
        else $error("unimplemented function returned data");

endmodule // eicp_core

// ==== core/eicp_msi_fmt.sv ====
// forms the address and payload of one msi memory write
// assumes the capability fields are stable while a request is taken
`timescale 1ns/1ps
module eicp_msi_fmt (
    // capability fields
    input wire logic [2:0] mme_i,
    input wire logic [31:0] addr_lo_i,
    input wire logic [31:0] addr_hi_i,
    input wire logic [31:0] data_i,
    // user vector
    input wire logic [31:0] vector_i,
    // formed message, valid bit left low
    output eicp_pkg::eicp_msg_type msg_o,
    output logic [31:0] vmask_o
);

    // lesser of capable and enabled vector counts, as a bit count
    function automatic logic [2:0] eicp_min3(input logic [2:0] a,
                                             input logic [2:0] b);
        eicp_min3 = (a < b) ? a : b;
    endfunction

    logic [2:0] nbits;

    always_comb begin
        nbits = eicp_min3(mme_i, eicp_pkg::MMC_CFG);
        vmask_o = ~(32'hffff_ffff << nbits);
        msg_o.valid = 1'b0;
        msg_o.addr = {addr_hi_i, addr_lo_i};
        msg_o.data = (data_i & ~vmask_o) | (vector_i & vmask_o);
        // short form unless software placed a nonzero upper address
        if (addr_hi_i != 32'h0000_0000) begin
            msg_o.kind = eicp_pkg::MSG_MSI64;
        end else begin
            msg_o.kind = eicp_pkg::MSG_MSI32;
        end
    end

endmodule // eicp_msi_fmt

// ==== core/eicp_pkg.sv ====
// shared constants and types of the endpoint interrupt and config port
// assumes a single core user clock and an active-low async reset
package eicp_pkg;

    // ------------------------------------------------------------
    // config space words (dword index) and fields
    // ------------------------------------------------------------
    localparam int unsigned MEM_AW = 6;
    localparam logic [9:0] ID_WORD = 10'h000;
    localparam logic [9:0] CMD_WORD = 10'h001;
    localparam logic [9:0] TYPE1_LAST_WORD = 10'h00f;
    localparam logic [9:0] MSI_CTRL_WORD = 10'h012;
    localparam logic [9:0] MSI_ADDR_LO_WORD = 10'h013;
    localparam logic [9:0] MSI_ADDR_HI_WORD = 10'h014;
    localparam logic [9:0] MSI_DATA_WORD = 10'h015;
    localparam logic [9:0] MSI_MASK_WORD = 10'h016;
    localparam logic [9:0] MSIX_CTRL_WORD = 10'h018;
    localparam int unsigned INTX_DIS_BIT = 10;
    localparam int unsigned MSI_EN_BIT = 16;
    localparam int unsigned MMC_LSB = 17;
    localparam int unsigned MME_LSB = 20;
    localparam int unsigned MSIX_EN_BIT = 31;
    localparam logic [2:0] MMC_CFG = 3'h5;
    localparam logic [31:0] CMD_WMASK = 32'h0000_ffff;
    localparam logic [31:0] MSI_CTRL_WMASK = 32'h0071_0000;
    localparam logic [31:0] MSIX_CTRL_WMASK = 32'hc000_0000;
    localparam logic [31:0] MEM_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum {ST_IDLE, ST_ACK, ST_MSG} eicp_irq_state_type;
    typedef enum {CS_IDLE, CS_ACC, CS_DONE} eicp_cfg_state_type;
    typedef enum logic [1:0] {
        MSG_ASSERT_INTA,
        MSG_DEASSERT_INTA,
        MSG_MSI32,
        MSG_MSI64
    } eicp_msg_kind_type;

    // one message toward the transaction layer
    typedef struct packed {
        logic valid;
        eicp_msg_kind_type kind;
        logic [63:0] addr;
        logic [31:0] data;
    } eicp_msg_type;

    typedef struct packed {
        eicp_irq_state_type irq;
        eicp_cfg_state_type cfg;
        logic is_msi;
        logic send;
        eicp_msg_type msg;
        logic [31:0] rdata;
        logic [15:0] command;
        logic msi_en;
        logic [2:0] mme;
        logic msix_en;
        logic [31:0] addr_lo;
        logic [31:0] addr_hi;
        logic [31:0] msg_data;
    } eicp_state_type;

    typedef struct packed {
        logic [(1 << MEM_AW) - 1:0][31:0] words;
        logic [31:0] rdata;
    } eicp_mem_state_type;

endpackage

// ==== tb/eicp_user_model.sv ====
// user logic model driving the interrupt and configuration ports
// assumes done and sent from the core are one-cycle pulses
`timescale 1ns/1ps
module eicp_user_model (
    // clock
    input wire logic clock_i,
    // answers from the core
    input wire logic int_sent_i,
    input wire logic msi_sent_i,
    input wire logic cfg_done_i,
    input wire logic [31:0] cfg_read_data_i,
    // requests toward the core
    output logic int_req_o,
    output logic int_pending_o,
    output logic [31:0] msi_int_o,
    output logic [17:0] cfg_addr_o,
    output logic [31:0] cfg_write_data_o,
    output logic [3:0] cfg_byte_enable_o,
    output logic cfg_write_o,
    output logic cfg_read_o,
    output logic type1_readonly_override_o
);
    // idle values at time zero
    initial begin
        {int_req_o, int_pending_o, cfg_write_o, cfg_read_o} = 4'h0;
        {msi_int_o, cfg_write_data_o, cfg_byte_enable_o} = 68'h0;
        cfg_addr_o = 18'h0;
        type1_readonly_override_o = 1'b0;
    end

    // one config access; held until done, then released with junk lines
    task automatic cfg_access(input logic wr, input logic [17:0] a,
        input logic [31:0] d, input logic [3:0] be, input logic ovr,
        output logic [31:0] rd, output int lat);
        lat = 0;
        cfg_addr_o <= a;
        cfg_write_data_o <= d;
        cfg_byte_enable_o <= be;
        type1_readonly_override_o <= ovr;
        cfg_write_o <= wr;
        cfg_read_o <= !wr;
        do begin
            @(posedge clock_i);
            lat++;
        end while (cfg_done_i !== 1'b1 && lat < 12);
        rd = cfg_read_data_i;
        cfg_write_o <= 1'b0;
        cfg_read_o <= 1'b0;
        cfg_addr_o <= ~a;
        cfg_write_data_o <= ~d;
        cfg_byte_enable_o <= ~be;
        type1_readonly_override_o <= 1'b0;
        // a gap cycle keeps the next strobe off this time step
        @(posedge clock_i);
    endtask

    // one interrupt request, held until the accepted pulse
    task automatic interrupt(input logic msi, input logic pend,
        input logic [31:0] v, output int lat);
        lat = 0;
        if (msi) msi_int_o <= v;
        else begin
            int_req_o <= 1'b1;
            int_pending_o <= pend;
        end
        do begin
            @(posedge clock_i);
            lat++;
        end while (int_sent_i !== 1'b1 && msi_sent_i !== 1'b1 && lat < 8);
        int_req_o <= 1'b0;
        int_pending_o <= ~pend;
        msi_int_o <= 32'h0;
    endtask
endmodule // eicp_user_model

// ==== tb/endpoint_irq_and_cfg_port_tb.sv ====
// self-checking bench of the interrupt logic and config port
// assumes the core plus the user model; bench acts as transaction layer
`timescale 1ns/1ps
module endpoint_irq_and_cfg_port_tb;
    logic clock_i, rst_n_i, root_port_mode_i, msg_ready_i;
    logic int_req_i, int_pending_i, int_sent_o, msi_sent_o;
    logic msi_enable_o, msix_enable_o, cfg_write_i, cfg_read_i;
    logic type1_readonly_override_i, cfg_done_o;
    logic [31:0] msi_int_i, cfg_write_data_i, cfg_read_data_o;
    logic [31:0] rd, d, cmd, ctrl, lo, hi, md, v;
    logic [2:0] msi_mmenable_o;
    logic [15:0] command_o;
    logic [17:0] cfg_addr_i;
    logic [3:0] cfg_byte_enable_i, be;
    eicp_pkg::eicp_msg_type msg_o;
    int lat;
    int num_errors = 0;
    int checks_done = 0;

    eicp_core uut (
        .clock_i(clock_i), .rst_n_i(rst_n_i),
        .root_port_mode_i(root_port_mode_i), .int_req_i(int_req_i),
        .int_pending_i(int_pending_i), .int_sent_o(int_sent_o),
        .msi_int_i(msi_int_i), .msi_sent_o(msi_sent_o),
        .msi_enable_o(msi_enable_o), .msi_mmenable_o(msi_mmenable_o),
        .msix_enable_o(msix_enable_o), .command_o(command_o),
        .cfg_addr_i(cfg_addr_i), .cfg_write_data_i(cfg_write_data_i),
        .cfg_byte_enable_i(cfg_byte_enable_i), .cfg_write_i(cfg_write_i),
        .cfg_read_i(cfg_read_i),
        .type1_readonly_override_i(type1_readonly_override_i),
        .cfg_read_data_o(cfg_read_data_o), .cfg_done_o(cfg_done_o),
        .msg_o(msg_o), .msg_ready_i(msg_ready_i)
    );
    eicp_user_model user (
        .clock_i(clock_i), .int_sent_i(int_sent_o), .msi_sent_i(msi_sent_o),
        .cfg_done_i(cfg_done_o), .cfg_read_data_i(cfg_read_data_o),
        .int_req_o(int_req_i), .int_pending_o(int_pending_i),
        .msi_int_o(msi_int_i), .cfg_addr_o(cfg_addr_i),
        .cfg_write_data_o(cfg_write_data_i),
        .cfg_byte_enable_o(cfg_byte_enable_i), .cfg_write_o(cfg_write_i),
        .cfg_read_o(cfg_read_i),
        .type1_readonly_override_o(type1_readonly_override_i)
    );

    // ------------------------------------------------------------
    // checking and expectation helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // byte lanes merge, read-only bits keep their old value
    function automatic logic [31:0] merge(input logic [31:0] old, nw,
        input logic [3:0] b, input logic [31:0] wm);
        logic [31:0] m;
        m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & wm;
        return (old & ~m) | (nw & m);
    endfunction

    // low bits of the payload come from the vector, capped at five
    function automatic logic [31:0] msi_data(input logic [31:0] dd, vv,
        input logic [2:0] mme);
        logic [31:0] m;
        m = (32'h1 << ((mme > 3'h5) ? 3'h5 : mme)) - 32'h1;
        return ({16'h0, dd[15:0]} & ~m) | (vv & m);
    endfunction

    task automatic wr(input logic [9:0] w, input logic [31:0] dd,
        input logic [3:0] b, input logic ovr);
        user.cfg_access(1'b1, 18'(w), dd, b, ovr, rd, lat);
        chk(64'(lat), 64'h3);
    endtask

    task automatic rdchk(input logic [17:0] a, input logic [31:0] exp);
        user.cfg_access(1'b0, a, 32'h0, 4'h0, 1'b0, rd, lat);
        chk(64'(lat), 64'h3);
        chk(64'(rd), 64'(exp));
    endtask

    task automatic irq(input logic msi, input logic pend,
        input logic [31:0] vv, input logic sent);
        user.interrupt(msi, pend, vv, lat);
        chk(64'(lat), sent ? 64'h2 : 64'h8);
    endtask

    // transaction layer: stalls a while, then takes one message
    task automatic take(input logic want, input eicp_pkg::eicp_msg_kind_type k,
        input logic [63:0] a, input logic [31:0] dd);
        int n;
        n = 0;
        repeat ($urandom_range(3)) @(posedge clock_i);
        msg_ready_i <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (msg_o.valid !== 1'b1 && n < 12);
        chk(64'(msg_o.valid), 64'(want));
        if (want) begin
            chk(64'(msg_o.kind), 64'(k));
            chk(msg_o.addr, a);
            chk(64'(msg_o.data), 64'(dd));
        end
        msg_ready_i <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    // the run needs about 500 cycles; this is sixty times that
    initial begin
        #240000;
        num_errors++;
        results();
    end

    initial begin
        rst_n_i = 1'b0;
        root_port_mode_i = 1'b0;
        msg_ready_i = 1'b0;
        void'($urandom(36176));
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        chk(64'({command_o, msi_enable_o, msi_mmenable_o, msix_enable_o}),
            64'h0);
        // command word with random data and byte lanes
        cmd = 32'h0;
        for (int i = 0; i < 8; i++) begin
            d = $urandom();
            be = (i == 0) ? 4'hf : 4'($urandom());
            wr(eicp_pkg::CMD_WORD, d, be, 1'b0);
            cmd = merge(cmd, d, be, eicp_pkg::CMD_WMASK);
            chk(64'(command_o), 64'(cmd[15:0]));
            rdchk(18'(eicp_pkg::CMD_WORD), cmd);
        end
        // other functions and words past the store are refused
        user.cfg_access(1'b1, {8'h01, eicp_pkg::CMD_WORD}, ~cmd,
            4'hf, 1'b0, rd, lat);
        rdchk(18'(eicp_pkg::CMD_WORD), cmd);
        rdchk({8'h01, eicp_pkg::CMD_WORD}, 32'h0);
        rdchk(18'h00040, 32'h0);
        // identity word only opens to override in root port mode
        d = $urandom();
        wr(eicp_pkg::ID_WORD, d, 4'hf, 1'b1);
        rdchk(18'(eicp_pkg::ID_WORD), 32'h0);
        root_port_mode_i <= 1'b1;
        wr(eicp_pkg::ID_WORD, d, 4'hf, 1'b0);
        rdchk(18'(eicp_pkg::ID_WORD), 32'h0);
        wr(eicp_pkg::ID_WORD, d, 4'hf, 1'b1);
        rdchk(18'(eicp_pkg::ID_WORD), d);
        // legacy assert and withdraw, then with the disable bit set
        wr(eicp_pkg::CMD_WORD, 32'h0, 4'hf, 1'b0);
        irq(1'b0, 1'b1, 32'h0, 1'b1);
        take(1'b1, eicp_pkg::MSG_ASSERT_INTA, 64'h0, 32'h0);
        irq(1'b0, 1'b0, 32'h0, 1'b1);
        take(1'b1, eicp_pkg::MSG_DEASSERT_INTA, 64'h0, 32'h0);
        wr(eicp_pkg::CMD_WORD, 32'h400, 4'h2, 1'b0);
        irq(1'b0, 1'b1, 32'h0, 1'b1);
        take(1'b0, eicp_pkg::MSG_ASSERT_INTA, 64'h0, 32'h0);
        // msi over every enable code, both address forms, mask all set
        // the core keeps the target dword aligned, so bits 1:0 stay zero
        lo = $urandom() & 32'hffff_fffc;
        md = $urandom();
        ctrl = 32'h0;
        wr(eicp_pkg::MSI_ADDR_LO_WORD, lo, 4'hf, 1'b0);
        wr(eicp_pkg::MSI_DATA_WORD, md, 4'hf, 1'b0);
        wr(eicp_pkg::MSI_MASK_WORD, 32'hffff_ffff, 4'hf, 1'b0);
        rdchk(18'(eicp_pkg::MSI_MASK_WORD), 32'hffff_ffff);
        for (int i = 0; i < 16; i++) begin
            hi = (i >= 8) ? ($urandom() | 32'h1) : 32'h0;
            wr(eicp_pkg::MSI_ADDR_HI_WORD, hi, 4'hf, 1'b0);
            d = ($urandom() & ~32'h0070_0000) | 32'h0001_0000;
            d = d | (32'(i % 8) << eicp_pkg::MME_LSB);
            wr(eicp_pkg::MSI_CTRL_WORD, d, 4'hf, 1'(i));
            ctrl = merge(ctrl, d, 4'hf, eicp_pkg::MSI_CTRL_WMASK);
            rdchk(18'(eicp_pkg::MSI_CTRL_WORD), ctrl | 32'h000a_0000);
            chk(64'({msi_enable_o, msi_mmenable_o}), 64'(8 + i % 8));
            v = $urandom() | 32'h1;
            irq(1'b1, 1'b0, v, 1'b1);
            take(1'b1, (hi != 0) ? eicp_pkg::MSG_MSI64 : eicp_pkg::MSG_MSI32,
                {hi, lo}, msi_data(md, v, 3'(i % 8)));
        end
        irq(1'b0, 1'b1, 32'h0, 1'b0);
        // msi-x enable bit and its read-only neighbours
        wr(eicp_pkg::MSIX_CTRL_WORD, 32'hffff_ffff, 4'hf, 1'b0);
        chk(64'(msix_enable_o), 64'h1);
        rdchk(18'(eicp_pkg::MSIX_CTRL_WORD), 32'hc000_0000);
        results();
    end
endmodule // endpoint_irq_and_cfg_port_tb
